// >>> include/pcss_pkg.sv
// Constants, codes and timing counts for the pulse-count supply sequencer.
// Assumes a single 50 MHz clock; analog comparators arrive as digital level inputs.
//
// How it works
// - On enable the negative rail starts at its default level, the other rails only after a power-on reset, and pins steer discharge and slew.
// - Rising edges on the pulse pin are counted; the total picks the setting.
// - Counts 1 to 41 set the negative rail from -5.4V to -1.4V in 0.1V steps.
// - Counts 42 to 49 set the analog rail from 7.9V to 5.8V in 0.3V steps.
// - Count 50 forces discharge on, count 51 forces it off, over the select pin.
// - Transition time follows the cap pin; counts 52 and 53 are reserved.
// - Positive pixel rail defaults to 4.6V; counts 54 to 57 select 4.7V to 5.0V.
// - Settings are volatile and cleared only by the defined reset conditions.
// - Without programming, the pulse pin held high is a plain enable.
// - The first rising edge makes discharge follow the select pin.
// - Disabled converters discharge outputs if select is high, else float them.
// - Analog enable starts a 1.5ms ramp, then the current limit drops to 0.2A.
// - Pulse pin high starts the positive converter at 0.2A until it regulates.
// - The negative converter starts 10ms after the pulse pin rises, at 0.4A until regulating.
// - A grounded or floating cap pin selects the fastest negative-rail transition.
// - Any short or analog overload latches a whole-device shutdown.
// - The fault clears by power cycle or both enables low for the shutdown time.
// - Start-up fails if positive rail unregulated at 10ms or negative at 20ms.
// - Analog rail short supervision begins only after its ramp completes.
// - Analog or positive rail below 90% for over 1ms shuts everything down.
// - Negative rail over 500mV above target for over 1ms shuts everything down.
// - Positive and negative rails shorted together counts as a short.
// - A programmed discharge mode overrides the select pin until power-on reset or the first enable edge after a shutdown low period.

package pcss_pkg;

   // ******************************************
   // Timing
   // ******************************************
   localparam int CLK_HZ        = 50_000_000;
   localparam int T_ACCEPT_US   = 55;
   localparam int T_OFF_US      = 55;
   localparam int T_RAMP_US     = 1500;
   localparam int T_NEG_DLY_MS  = 10;
   localparam int T_POS_CHK_MS  = 10;
   localparam int T_NEG_CHK_MS  = 20;
   localparam int T_OPER_MS     = 1;
   localparam int CYC_ACCEPT    = T_ACCEPT_US * (CLK_HZ / 1_000_000);
   localparam int CYC_OFF       = T_OFF_US * (CLK_HZ / 1_000_000);
   localparam int CYC_RAMP      = T_RAMP_US * (CLK_HZ / 1_000_000);
   localparam int CYC_NEG_DLY   = T_NEG_DLY_MS * (CLK_HZ / 1000);
   localparam int CYC_POS_CHK   = T_POS_CHK_MS * (CLK_HZ / 1000);
   localparam int CYC_NEG_CHK   = T_NEG_CHK_MS * (CLK_HZ / 1000);
   localparam int CYC_OPER      = T_OPER_MS * (CLK_HZ / 1000);

   // ******************************************
   // Edge-count codes
   // ******************************************
   localparam logic [5:0] CNT_NEG_LO  = 6'h01;
   localparam logic [5:0] CNT_NEG_HI  = 6'h29;
   localparam logic [5:0] CNT_ANA_LO  = 6'h2a;
   localparam logic [5:0] CNT_ANA_HI  = 6'h31;
   localparam logic [5:0] CNT_DCH_ON  = 6'h32;
   localparam logic [5:0] CNT_DCH_OFF = 6'h33;
   localparam logic [5:0] CNT_POS_LO  = 6'h36;
   localparam logic [5:0] CNT_POS_HI  = 6'h39;
   localparam logic [5:0] CNT_MAX     = 6'h3f;

   // ******************************************
   // Reset settings (codes are step indices)
   // ******************************************
   localparam logic [5:0] NEG_DEFAULT = 6'h1e;   // Code 30 is -2.5V.
   localparam logic [2:0] ANA_DEFAULT = 3'h6;    // Step 6 from 7.9V is 6.1V.
   localparam logic [2:0] POS_DEFAULT = 3'h0;    // Step 0 is 4.6V.

   typedef enum logic [1:0] {PCSS_DCH_FOLLOW, PCSS_DCH_ON, PCSS_DCH_OFF} pcss_dch_t;
   typedef enum logic [1:0] {PCSS_OFF, PCSS_START, PCSS_RUN, PCSS_FAULT} pcss_state_t;

endpackage

// >>> design/pcss_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin levels and the single system clock.

`timescale 1ns/1ps
`default_nettype none

module pcss_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and filtered level
   input  wire logic din,
   output logic      dout
);

   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // The level changes only once the last two stages agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= RST_VAL;
      end else if (s2 == s3) begin
         dout <= s3;
      end
   end

endmodule

`default_nettype wire

// >>> design/pcss_top.sv
// Pulse-count programming, start-up sequencing and fault latch of the supply.
// Assumes comparator results arrive as asynchronous pin levels; rst_n is power-on reset.

`timescale 1ns/1ps
`default_nettype none

module pcss_top
   import pcss_pkg::*;
#(
   parameter int ACCEPT_CYC = CYC_ACCEPT,
   parameter int OFF_CYC    = CYC_OFF,
   parameter int RAMP_CYC   = CYC_RAMP,
   parameter int NEG_DLY    = CYC_NEG_DLY,
   parameter int POS_CHK    = CYC_POS_CHK,
   parameter int NEG_CHK    = CYC_NEG_CHK,
   parameter int OPER_CYC   = CYC_OPER
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control pins
   input  wire logic       pulse_ctrl_pin,
   input  wire logic       analog_rail_enable_pin,
   input  wire logic       discharge_select_pin,
   input  wire logic       transition_cap_low,
   // Rail supervision comparators
   input  wire logic       pos_regulating,
   input  wire logic       neg_regulating,
   input  wire logic       pos_below_90,
   input  wire logic       ana_below_90,
   input  wire logic       neg_above_500mv,
   input  wire logic       ana_overload,
   input  wire logic       pos_neg_shorted,
   // Rail settings
   output logic [5:0]      neg_level_code,
   output logic [2:0]      ana_level_code,
   output logic [2:0]      pos_level_code,
   output logic            fast_transition,
   // Converter controls
   output logic            analog_supply_output_en,
   output logic            analog_ramp_active,
   output logic            analog_low_limit,
   output logic            positive_pixel_output_en,
   output logic            positive_low_limit,
   output logic            negative_pixel_output_en,
   output logic            negative_low_limit,
   output logic            discharge_active,
   output logic            fault_latched
);

   // ******************************************
   // Elaboration checks
   // ******************************************
   initial begin
      if (ACCEPT_CYC < 2 || OFF_CYC < 2 || NEG_DLY < 1 || NEG_CHK <= NEG_DLY ||
          POS_CHK < 1 || RAMP_CYC < 1 || OPER_CYC < 1 || NEG_CHK >= (1 << 24))
         $error("pcss_top: timing parameters out of range");
   end

   function automatic logic cnt_done(input logic [23:0] c, input int lim);
      return c >= 24'(lim);
   endfunction

   // ******************************************
   // Input synchronisation
   // ******************************************
   logic ctl;
   logic ana_en;
   logic fd;
   logic ct_low;
   logic pos_ok;
   logic neg_ok;
   logic pos_lo;
   logic ana_lo;
   logic neg_hi;
   logic ana_ol;
   logic pn_sh;

   pcss_sync u_s_ctl (.clk(clk), .rst_n(rst_n), .din(pulse_ctrl_pin), .dout(ctl));
   pcss_sync u_s_ana (.clk(clk), .rst_n(rst_n), .din(analog_rail_enable_pin), .dout(ana_en));
   pcss_sync u_s_fd  (.clk(clk), .rst_n(rst_n), .din(discharge_select_pin), .dout(fd));
   pcss_sync u_s_ct  (.clk(clk), .rst_n(rst_n), .din(transition_cap_low), .dout(ct_low));
   pcss_sync u_s_pok (.clk(clk), .rst_n(rst_n), .din(pos_regulating), .dout(pos_ok));
   pcss_sync u_s_nok (.clk(clk), .rst_n(rst_n), .din(neg_regulating), .dout(neg_ok));
   pcss_sync u_s_plo (.clk(clk), .rst_n(rst_n), .din(pos_below_90), .dout(pos_lo));
   pcss_sync u_s_alo (.clk(clk), .rst_n(rst_n), .din(ana_below_90), .dout(ana_lo));
   pcss_sync u_s_nhi (.clk(clk), .rst_n(rst_n), .din(neg_above_500mv), .dout(neg_hi));
   pcss_sync u_s_aol (.clk(clk), .rst_n(rst_n), .din(ana_overload), .dout(ana_ol));
   pcss_sync u_s_psh (.clk(clk), .rst_n(rst_n), .din(pos_neg_shorted), .dout(pn_sh));

   logic ctl_d;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ctl_d <= 1'b0;
      else        ctl_d <= ctl;
   end
   wire ctl_rise = ctl & ~ctl_d;

   // ******************************************
   // Edge counting and acceptance
   // ******************************************
   logic [5:0]  edge_cnt;
   logic [23:0] hi_cnt;
   logic        accept;
   logic        pending;
   logic        off_timer_hit;

   // A shutdown low period also drops a half-counted burst, so the next enable is clean.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_cnt <= 6'h00;
         pending  <= 1'b0;
      end else if (accept || off_timer_hit || !fault_latched && ctl_d && !ctl && !pending) begin
         edge_cnt <= 6'h00;
         pending  <= 1'b0;
      end else if (ctl_rise) begin
         edge_cnt <= (edge_cnt == CNT_MAX) ? CNT_MAX : edge_cnt + 6'h01;
         pending  <= 1'b1;
      end
   end

   // The first rising edge is the enable itself; a lone edge is not a code.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 24'h0;
         accept <= 1'b0;
      end else begin
         hi_cnt <= (ctl && !ctl_rise) ? hi_cnt + 24'h1 : 24'h0;
         accept <= pending && ctl && (hi_cnt == 24'(ACCEPT_CYC - 1));
      end
   end

   // Counts beyond the first enable edge are the programming code.
   logic        first_done;
   logic        en_burst;
   logic [5:0]  code;
   assign code = en_burst ? edge_cnt - 6'h01 : edge_cnt;

   // A burst that began with the enable edge carries one edge that is not part of the code.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_burst <= 1'b0;
      end else if (accept || off_timer_hit) begin
         en_burst <= 1'b0;
      end else if (ctl_rise && !first_done) begin
         en_burst <= 1'b1;
      end
   end

   // ******************************************
   // Settings storage
   // ******************************************
   pcss_dch_t dch_mode;
   logic      both_low_hit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         neg_level_code <= NEG_DEFAULT;
         ana_level_code <= ANA_DEFAULT;
         pos_level_code <= POS_DEFAULT;
      end else begin
         if (off_timer_hit) neg_level_code <= NEG_DEFAULT;
         if (accept) begin
            if (code >= CNT_NEG_LO && code <= CNT_NEG_HI)
               neg_level_code <= code;
            else if (code >= CNT_ANA_LO && code <= CNT_ANA_HI)
               ana_level_code <= 3'(code - CNT_ANA_LO);
            else if (code >= CNT_POS_LO && code <= CNT_POS_HI)
               pos_level_code <= 3'(code - CNT_POS_LO + 6'h01);
            // Reserved and undefined codes change nothing.
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dch_mode   <= PCSS_DCH_FOLLOW;
         first_done <= 1'b0;
      end else if (ctl_rise && !first_done) begin
         dch_mode   <= PCSS_DCH_FOLLOW;
         first_done <= 1'b1;
      end else if (off_timer_hit) begin
         first_done <= 1'b0;
      end else if (accept && code == CNT_DCH_ON) begin
         dch_mode   <= PCSS_DCH_ON;
      end else if (accept && code == CNT_DCH_OFF) begin
         dch_mode   <= PCSS_DCH_OFF;
      end
   end

   // ******************************************
   // Sequencing timers
   // ******************************************
   logic [23:0] off_cnt;
   logic [23:0] both_cnt;
   logic [23:0] ctl_on_cnt;
   logic [23:0] ramp_cnt;
   logic [23:0] op_cnt;
   logic        ramp_done;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         off_cnt  <= 24'h0;
         both_cnt <= 24'h0;
      end else begin
         off_cnt  <= ctl ? 24'h0 : (cnt_done(off_cnt, OFF_CYC) ? off_cnt : off_cnt + 24'h1);
         both_cnt <= (ctl || ana_en) ? 24'h0 :
                     (cnt_done(both_cnt, OFF_CYC) ? both_cnt : both_cnt + 24'h1);
      end
   end
   assign off_timer_hit = (off_cnt == 24'(OFF_CYC - 1));
   assign both_low_hit  = (both_cnt == 24'(OFF_CYC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_on_cnt <= 24'h0;
         ramp_cnt   <= 24'h0;
      end else begin
         ctl_on_cnt <= (!ctl || fault_latched) ? 24'h0 :
                       (cnt_done(ctl_on_cnt, NEG_CHK) ? ctl_on_cnt : ctl_on_cnt + 24'h1);
         ramp_cnt   <= (!ana_en || fault_latched) ? 24'h0 :
                       (cnt_done(ramp_cnt, RAMP_CYC) ? ramp_cnt : ramp_cnt + 24'h1);
      end
   end
   assign ramp_done = cnt_done(ramp_cnt, RAMP_CYC);

   // ******************************************
   // Fault supervision
   // ******************************************
   logic startup_fail;
   logic oper_low;
   logic fault_set;

   assign startup_fail = (ctl_on_cnt == 24'(POS_CHK) && !pos_ok) ||
                         (ctl_on_cnt == 24'(NEG_CHK) && !neg_ok);
   assign oper_low = (ramp_done && ana_lo) ||
                     (cnt_done(ctl_on_cnt, POS_CHK) && pos_lo) ||
                     (cnt_done(ctl_on_cnt, NEG_CHK) && neg_hi);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) op_cnt <= 24'h0;
      else        op_cnt <= oper_low ? (cnt_done(op_cnt, OPER_CYC) ? op_cnt : op_cnt + 24'h1)
                                     : 24'h0;
   end

   assign fault_set = startup_fail || op_cnt == 24'(OPER_CYC) ||
                      (ramp_done && ana_ol) || (ctl && pn_sh);

   // A fault raised in the same cycle as the release wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)           fault_latched <= 1'b0;
      else if (fault_set)   fault_latched <= 1'b1;
      else if (both_low_hit) fault_latched <= 1'b0;
   end

   // ******************************************
   // Converter controls
   // ******************************************
   logic dch_en;
   always_comb begin
      unique case (dch_mode)
         PCSS_DCH_ON:  dch_en = 1'b1;
         PCSS_DCH_OFF: dch_en = 1'b0;
         default:      dch_en = fd;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         analog_supply_output_en  <= 1'b0;
         analog_ramp_active       <= 1'b0;
         analog_low_limit         <= 1'b0;
         positive_pixel_output_en <= 1'b0;
         positive_low_limit       <= 1'b0;
         negative_pixel_output_en <= 1'b0;
         negative_low_limit       <= 1'b0;
         discharge_active         <= 1'b0;
         fast_transition          <= 1'b0;
      end else begin
         analog_supply_output_en  <= ana_en && !fault_latched;
         analog_ramp_active       <= ana_en && !fault_latched && !ramp_done;
         analog_low_limit         <= ana_en && !fault_latched && ramp_done;
         positive_pixel_output_en <= ctl && !fault_latched;
         positive_low_limit       <= ctl && !fault_latched && !pos_ok;
         negative_pixel_output_en <= ctl && !fault_latched &&
                                     cnt_done(ctl_on_cnt, NEG_DLY);
         negative_low_limit       <= ctl && !fault_latched &&
                                     cnt_done(ctl_on_cnt, NEG_DLY) && !neg_ok;
         discharge_active         <= (!ctl || fault_latched) && dch_en;
         fast_transition          <= ct_low;
      end
   end

   // ******************************************
   // Assertions
   // ******************************************
   sequence s_fault_cause;
      fault_set;
   endsequence

   chk_fault_latches: assert property (@(posedge clk) disable iff (!rst_n)
      s_fault_cause |=> fault_latched)
      else $error("fault did not latch");

   chk_fault_gates_rails: assert property (@(posedge clk) disable iff (!rst_n)
      fault_latched |=> !positive_pixel_output_en && !analog_supply_output_en)
      else $error("rail enabled while fault latched");

   chk_fault_holds: assert property (@(posedge clk) disable iff (!rst_n)
      fault_latched && !$past(both_low_hit) && !both_low_hit |=> fault_latched)
      else $error("fault cleared without release");

   chk_neg_delay: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(negative_pixel_output_en) |-> cnt_done(ctl_on_cnt, NEG_DLY))
      else $error("negative converter started early");

   chk_dch_on_code: assert property (@(posedge clk) disable iff (!rst_n)
      accept && code == CNT_DCH_ON && !ctl_rise |=> dch_mode == PCSS_DCH_ON)
      else $error("discharge on code not applied");

   chk_reserved_keep: assert property (@(posedge clk) disable iff (!rst_n)
      accept && code > CNT_DCH_OFF && code < CNT_POS_LO && !off_timer_hit
      |=> $stable(neg_level_code) && $stable(ana_level_code) && $stable(pos_level_code))
      else $error("reserved code changed settings");

   chk_accept_high: assert property (@(posedge clk) disable iff (!rst_n)
      accept |-> $past(ctl) && pending)
      else $error("accept without held high line");

   chk_enable_no_code: assert property (@(posedge clk) disable iff (!rst_n)
      accept && en_burst && edge_cnt == 6'h01
      |=> $stable(neg_level_code) && $stable(ana_level_code) && $stable(pos_level_code))
      else $error("enable edge taken as a code");

   chk_ramp_limit: assert property (@(posedge clk) disable iff (!rst_n)
      analog_low_limit |-> !analog_ramp_active)
      else $error("low limit during ramp");

endmodule

`default_nettype wire

// >>> verification/pcss_host.sv
// Host model driving the pulse-control pin of the supply sequencer.
// Assumes the bench calls its tasks; each pulse is 8 clocks low, 8 high.

`timescale 1ns/1ps
`default_nettype none

module pcss_host (
   // Clock and pin
   input  wire logic clk,
   output var logic  pin
);
   initial pin = 1'b0;

   // The pin moves 1 ns after an edge, like every other bench input.
   task automatic set_level(input logic v);
      @(posedge clk);
      #1 pin = v;
   endtask

   // The burst ends high; the bench keeps it high past the accept time.
   task automatic send(input logic [5:0] n);
      for (int i = 0; i < int'(n); i++) begin
         set_level(1'b0);
         repeat (7) @(posedge clk);
         set_level(1'b1);
         repeat (7) @(posedge clk);
      end
   endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the pulse-count supply sequencer.
// Assumes pcss_host drives the pulse pin; comparator levels are set here.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import pcss_pkg::*;
   // Short sequencing counts keep the run small; accept and off times stay at their defaults.
   localparam int ACC = CYC_ACCEPT, OFF = CYC_OFF, RMP = 40, OPR = 30, PCK = 100;
   localparam int NDL = 100, NCK = 200;
   logic       clk = 1'b0;
   logic       rst_n;
   logic       pin;
   logic       ana_en, dsel, ct_low;
   logic       pos_reg, neg_reg;
   logic [4:0] flt;
   logic [5:0] neg_c;
   logic [2:0] ana_c, pos_c;
   logic       fast, a_en, a_rmp, a_lim, p_en, p_lim, n_en, n_lim, dch, fault;
   int         errors = 0, n_compared = 0;

   always #10 clk = ~clk;

   pcss_host host (.clk(clk), .pin(pin));

   pcss_top #(.RAMP_CYC(RMP), .NEG_DLY(NDL), .POS_CHK(PCK), .NEG_CHK(NCK),
      .OPER_CYC(OPR)) DUT (
      .clk(clk), .rst_n(rst_n), .pulse_ctrl_pin(pin), .analog_rail_enable_pin(ana_en),
      .discharge_select_pin(dsel), .transition_cap_low(ct_low),
      .pos_regulating(pos_reg), .neg_regulating(neg_reg), .pos_below_90(flt[3]),
      .ana_below_90(flt[4]), .neg_above_500mv(flt[2]), .ana_overload(flt[0]),
      .pos_neg_shorted(flt[1]), .neg_level_code(neg_c), .ana_level_code(ana_c),
      .pos_level_code(pos_c), .fast_transition(fast), .analog_supply_output_en(a_en),
      .analog_ramp_active(a_rmp), .analog_low_limit(a_lim),
      .positive_pixel_output_en(p_en), .positive_low_limit(p_lim),
      .negative_pixel_output_en(n_en), .negative_low_limit(n_lim),
      .discharge_active(dch), .fault_latched(fault));

   // ******************************************
   // Shared tasks
   // ******************************************
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("Compares %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ******************************************
   // Scenarios
   // ******************************************
   task automatic t_reset;
      check("neg default", neg_c, NEG_DEFAULT);
      check("ana default", ana_c, ANA_DEFAULT);
      check("pos default", pos_c, POS_DEFAULT);
      ct_low = 1'b1;
      w(10);
      check("fast on", fast, 6'h01);
      ct_low = 1'b0;
      w(10);
      check("fast off", fast, 6'h00);
   endtask

   task automatic t_enable;
      host.set_level(1'b1);
      w(10);
      check("pos en", p_en, 6'h01);
      check("pos low lim", p_lim, 6'h01);
      pos_reg = 1'b1;
      w(10);
      check("pos full lim", p_lim, 6'h00);
      w(60);
      check("neg en early", n_en, 6'h00);
      w(30);
      check("neg en", n_en, 6'h01);
      check("neg low lim", n_lim, 6'h01);
      neg_reg = 1'b1;
      w(10);
      check("neg full lim", n_lim, 6'h00);
   endtask

   task automatic t_program;
      logic [5:0] codes [8] = '{6'h29, 6'h2a, 6'h36, 6'h31, 6'h39, 6'h01, 6'h34, 6'h3a};
      logic [5:0] en = NEG_DEFAULT;
      logic [2:0] ea = ANA_DEFAULT;
      logic [2:0] ep = POS_DEFAULT;
      foreach (codes[i]) begin
         host.send(codes[i]);
         w(ACC + 15);
         if (codes[i] <= 6'h29) en = codes[i];
         else if (codes[i] <= 6'h31) ea = 3'(codes[i] - 6'h2a);
         else if (codes[i] >= 6'h36 && codes[i] <= 6'h39) ep = 3'(codes[i] - 6'h35);
         check("neg code", neg_c, en);
         check("ana code", ana_c, 6'(ea));
         check("pos code", pos_c, 6'(ep));
      end
   endtask

   task automatic t_discharge;
      host.send(6'h32);
      w(ACC + 15);
      host.set_level(1'b0);
      w(OFF + 15);
      check("forced on", dch, 6'h01);
      check("pos off", p_en, 6'h00);
      check("neg back", neg_c, NEG_DEFAULT);
      check("ana kept", ana_c, 6'h07);
      host.set_level(1'b1);
      w(ACC + 15);
      check("enable only", neg_c, NEG_DEFAULT);
      host.set_level(1'b0);
      w(10);
      check("follow low", dch, 6'h00);
      dsel = 1'b1;
      w(10);
      check("follow high", dch, 6'h01);
      host.send(6'h33);
      w(ACC + 15);
      host.set_level(1'b0);
      w(10);
      check("forced off", dch, 6'h00);
   endtask

   task automatic t_analog;
      ana_en = 1'b1;
      flt[4] = 1'b1;
      w(10);
      check("ana en", a_en, 6'h01);
      check("ana ramp", a_rmp, 6'h01);
      w(25);
      flt[4] = 1'b0;
      w(RMP);
      check("ramp done", a_rmp, 6'h00);
      check("ana low lim", a_lim, 6'h01);
      check("no ramp fault", fault, 6'h00);
   endtask

   task automatic t_faults;
      for (int k = 0; k < 5; k++) begin
         ana_en = 1'b1;
         host.set_level(1'b1);
         w(250);
         check("healthy", fault, 6'h00);
         flt[k] = 1'b1;
         w(OPR + 15);
         check("fault set", fault, 6'h01);
         check("all off", p_en, 6'h00);
         flt = 5'h00;
         ana_en = 1'b0;
         host.set_level(1'b0);
         w(OFF - 8);
         check("fault held", fault, 6'h01);
         w(25);
         check("fault clear", fault, 6'h00);
      end
   endtask

   task automatic t_startup;
      pos_reg = 1'b0;
      host.set_level(1'b1);
      w(PCK - 15);
      check("before check", fault, 6'h00);
      w(30);
      check("start fail", fault, 6'h01);
   endtask

   // A supply cycle in mid-run while the pin stays high and a fault is latched.
   task automatic t_power_cycle;
      pos_reg = 1'b1;
      rst_n = 1'b0;
      w(4);
      check("reset fault", fault, 6'h00);
      check("reset ana", ana_c, ANA_DEFAULT);
      check("reset pos", pos_c, POS_DEFAULT);
      check("reset pos en", p_en, 6'h00);
      rst_n = 1'b1;
      w(2);
      check("still off", p_en, 6'h00);
      w(ACC + 15);
      check("enabled", p_en, 6'h01);
      check("enable no code", neg_c, NEG_DEFAULT);
      check("healthy again", fault, 6'h00);
   endtask

   initial begin
      rst_n = 1'b0;
      ana_en = 1'b0;
      dsel = 1'b0;
      ct_low = 1'b0;
      pos_reg = 1'b0;
      neg_reg = 1'b0;
      flt = 5'h00;
      w(4);
      rst_n = 1'b1;
      w(2);
      t_reset();
      t_enable();
      t_program();
      t_discharge();
      t_analog();
      t_faults();
      t_startup();
      t_power_cycle();
      give_verdict();
   end

   // A stuck sequence ends here rather than running forever.
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule

`default_nettype wire
